// ### ctrr_framer.sv
// Top of the readout record framer: captures patterns on accept and streams the record
//
// Behaviour
// - Words 1-5 carry the 160 aligned inputs, inputs 1-32 first, ascending.
// - Word 6 carries internal inputs: prescaled clocks, random, turn, crossing mask.
// - Words 7-9 carry the 96 items before veto, lowest items first.
// - Words 10-12 carry the 96 items after veto, ascending.
// - Words 13-15 carry the 96 items after prescaling, ascending.
// - Word 16 carries the 8-bit trigger type; sixteen data words in all.
// - Event number and crossing number go in the header, not data words.
// - With nothing queued, a record starts leaving in under 500 ns.
// - Two standard status words are sent in each record, normally clear.
// - No per-event error checking of the inputs is done.
// - Status bits 0-15 are standard; upper bits are source specific.
module ctrr_framer
   import ctrr_pkg::*;
#(
   parameter int FIFO_DEPTH = CTRR_FIFO_DEPTH
) (
   input wire logic CLOCK_IN,
   input wire logic ARST_N_IN,
   input wire logic ACCEPT_IN,
   input wire logic [CTRR_EXT_IN_W-1:0] EXT_INPUTS_IN,
   input wire logic [CTRR_WORD_W-1:0] INT_INPUTS_IN,
   input wire logic [CTRR_ITEMS_W-1:0] ITEMS_BEFORE_VETO_IN,
   input wire logic [CTRR_ITEMS_W-1:0] ITEMS_AFTER_VETO_IN,
   input wire logic [CTRR_ITEMS_W-1:0] ITEMS_AFTER_PRESCALE_IN,
   input wire logic [CTRR_TTYPE_W-1:0] TRIGGER_TYPE_IN,
   input wire logic [CTRR_EVNUM_W-1:0] EVENT_NUMBER_IN,
   input wire logic [CTRR_BCNUM_W-1:0] BUNCH_CROSSING_NUMBER_IN,
   input wire logic [CTRR_STD_STAT_W-1:0] STATUS_STD_IN,
   input wire logic [CTRR_WORD_W-CTRR_STD_STAT_W-1:0] STATUS_SRC_IN,
   output logic BUSY_OUT,
   output logic OVERRUN_OUT,
   output logic REC_VALID_OUT,
   input wire logic REC_READY_IN,
   output logic [CTRR_WORD_W-1:0] REC_DATA_OUT,
   output logic REC_LAST_OUT
);
   // *****************************************
   // Capture
   // *****************************************
   localparam int CW = CTRR_EXT_IN_W + CTRR_WORD_W + 3 * CTRR_ITEMS_W + CTRR_TTYPE_W;
   localparam int IDX_W = $clog2(CTRR_REC_WORDS);
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CTRR_REC_WORDS - 1);
   if (FIFO_DEPTH < CTRR_REC_WORDS - 4) begin : g_bad_fifo_depth
      $error("FIFO_DEPTH too small");
   end
   if (CTRR_REC_WORDS + 2 > CTRR_MAX_LAT_CYC + 10) begin : g_bad_budget
      $error("record too long for budget");
   end

   ctrr_state_t state_reg;
   logic [CW-1:0] snap_reg;
   logic [CTRR_EVNUM_W-1:0] evnum_reg;
   logic [CTRR_BCNUM_W-1:0] bcnum_reg;
   logic [CTRR_WORD_W-1:0] stat0_reg, stat1_reg;
   logic [IDX_W-1:0] idx_reg;
   logic [CTRR_WORD_W-1:0] word;
   logic take;

   ctrr_stream_if #(.W(CTRR_WORD_W + 1)) strm ();

   assign take = ACCEPT_IN && (state_reg == CTRR_IDLE);
   assign BUSY_OUT = (state_reg != CTRR_IDLE);

   // Snapshot is taken in the accept cycle so all words share one crossing
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         snap_reg <= '0;
         evnum_reg <= '0;
         bcnum_reg <= '0;
         stat0_reg <= CTRR_STAT_RESET;
         stat1_reg <= CTRR_STAT_RESET;
      end else if (take) begin
         snap_reg <= {TRIGGER_TYPE_IN, ITEMS_AFTER_PRESCALE_IN, ITEMS_AFTER_VETO_IN,
                      ITEMS_BEFORE_VETO_IN, INT_INPUTS_IN, EXT_INPUTS_IN};
         evnum_reg <= EVENT_NUMBER_IN;
         bcnum_reg <= BUNCH_CROSSING_NUMBER_IN;
         // Status inputs are passed through as given; nothing here checks data
         stat0_reg <= {STATUS_SRC_IN, STATUS_STD_IN};
         stat1_reg <= CTRR_STAT_RESET;
      end
   end

   // Accept while the framer is still sending a record into the FIFO cannot be served; flag it
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         OVERRUN_OUT <= 1'b0;
      end else begin
         OVERRUN_OUT <= ACCEPT_IN && (state_reg != CTRR_IDLE);
      end
   end

   // *****************************************
   // Word selection
   // *****************************************
   function automatic logic [CTRR_WORD_W-1:0] ctrr_slice(input logic [CW-1:0] s, input int n);
      ctrr_slice = s[n * CTRR_WORD_W +: CTRR_WORD_W];
   endfunction

   always_comb begin
      word = '0;
      unique case (idx_reg)
         IDX_W'(0): word = evnum_reg;
         IDX_W'(1): word = {{(CTRR_WORD_W - CTRR_BCNUM_W){1'b0}}, bcnum_reg};
         IDX_W'(2): word = stat0_reg;
         IDX_W'(3): word = stat1_reg;
         default: begin
            // Data words 0..14 map straight onto the snapshot in 32-bit slices; word 15 is the zero-extended trigger type
            word = ctrr_slice(snap_reg, int'(idx_reg) - 4);
            if (int'(idx_reg) - 4 == CTRR_POS_TT) begin
               word = {{(CTRR_WORD_W - CTRR_TTYPE_W){1'b0}},
                       snap_reg[CW-1 -: CTRR_TTYPE_W]};
            end
         end
      endcase
   end

   assign strm.valid = (state_reg == CTRR_SEND);
   assign strm.data = {(idx_reg == LAST_IDX), word};

   // *****************************************
   // Sequencer
   // *****************************************
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_reg <= CTRR_IDLE;
         idx_reg <= '0;
      end else begin
         unique case (state_reg)
            CTRR_IDLE: begin
               if (take) begin
                  state_reg <= CTRR_SEND;
                  idx_reg <= '0;
               end
            end
            CTRR_SEND: begin
               if (strm.ready) begin
                  if (idx_reg == LAST_IDX) begin
                     state_reg <= CTRR_IDLE;
                     idx_reg <= '0;
                  end else begin
                     idx_reg <= idx_reg + 1'b1;
                  end
               end
            end
            default: state_reg <= CTRR_IDLE;
         endcase
      end
   end

   logic [CTRR_WORD_W:0] fifo_q;
   ctrr_fifo #(.WIDTH(CTRR_WORD_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(CLOCK_IN),
      .arst_n_in(ARST_N_IN),
      .wr(strm),
      .rd_valid_out(REC_VALID_OUT),
      .rd_ready_in(REC_READY_IN),
      .rd_data_out(fifo_q)
   );
   assign REC_DATA_OUT = fifo_q[CTRR_WORD_W-1:0];
   assign REC_LAST_OUT = fifo_q[CTRR_WORD_W];

   // *****************************************
   // Checks
   // *****************************************
   AST_ONE_RECORD: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      take |=> (state_reg == CTRR_SEND) && (idx_reg == '0))
      else $error("accept did not start a record");
   AST_LATENCY: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (take && REC_READY_IN && !REC_VALID_OUT) |-> ##[1:12] REC_VALID_OUT)
      else $error("record not started in time");
   AST_SEND_LEN: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (take && strm.ready) ##1 strm.ready[*8] |=> (idx_reg == IDX_W'(8)))
      else $error("word index miscounted");
   AST_LAST_MARK: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (strm.valid && strm.ready && strm.data[CTRR_WORD_W]) |=> (state_reg == CTRR_IDLE))
      else $error("last word did not end record");
   AST_HDR_EVT: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      take |=> (evnum_reg == $past(EVENT_NUMBER_IN)) && (strm.data[31:0] == evnum_reg))
      else $error("header event number wrong");
   AST_EXT_W0: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (strm.valid && idx_reg == IDX_W'(4)) |-> (word == snap_reg[31:0]))
      else $error("first input word wrong");
   AST_TT_WORD: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (strm.valid && idx_reg == LAST_IDX) |-> (word[31:8] == 24'h000000))
      else $error("trigger type word upper bits set");
   AST_STAT1_CLEAR: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (strm.valid && idx_reg == IDX_W'(3)) |-> (word == CTRR_STAT_RESET))
      else $error("second status word not clear");
   AST_NO_RESTART: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (ACCEPT_IN && BUSY_OUT) |=> OVERRUN_OUT && $stable(snap_reg))
      else $error("accept during record disturbed it");
   AST_OVR_CAUSE: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      OVERRUN_OUT |-> $past(ACCEPT_IN) && $past(BUSY_OUT))
      else $error("overrun flagged without a refused accept");
   AST_TT_CAPTURE: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      take |=> (snap_reg[CW-1 -: CTRR_TTYPE_W] == $past(TRIGGER_TYPE_IN)))
      else $error("trigger type not taken from accept cycle");
   AST_EXT_CAPTURE: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      take |=> (snap_reg[CTRR_EXT_IN_W-1:0] == $past(EXT_INPUTS_IN)))
      else $error("inputs not taken from accept cycle");
   AST_STD_CAPTURE: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      take |=> (stat0_reg[CTRR_STD_STAT_W-1:0] == $past(STATUS_STD_IN)))
      else $error("standard status bits misplaced");
   AST_BC_HDR: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (strm.valid && idx_reg == IDX_W'(1)) |-> (word[CTRR_WORD_W-1:CTRR_BCNUM_W] == '0))
      else $error("crossing header word upper bits set");
   AST_INT_WORD: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (strm.valid && idx_reg == IDX_W'(CTRR_HDR_WORDS + CTRR_STAT_WORDS + CTRR_POS_INT))
      |-> (word == snap_reg[CTRR_EXT_IN_W +: CTRR_WORD_W]))
      else $error("internal inputs word misplaced");
   AST_IDX_RANGE: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      strm.valid |-> (idx_reg <= LAST_IDX))
      else $error("word index beyond record end");
   // An idle framer must not leak words, or the receiver would see a phantom record
   AST_IDLE_QUIET: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
      (state_reg == CTRR_IDLE) |-> !strm.valid && (idx_reg == '0))
      else $error("idle framer offered a word");
endmodule

// ### ctrr_pkg.sv
// Package with record layout, timing and sizing constants for the readout record framer
package ctrr_pkg;
   localparam int CTRR_WORD_W = 32;
   localparam int CTRR_EXT_IN_W = 160;
   localparam int CTRR_ITEMS_W = 96;
   localparam int CTRR_TTYPE_W = 8;
   localparam int CTRR_EVNUM_W = 32;
   localparam int CTRR_BCNUM_W = 12;
   // Record layout: header word count, data word positions
   localparam int CTRR_HDR_WORDS = 2;
   localparam int CTRR_STAT_WORDS = 2;
   localparam int CTRR_DATA_WORDS = 16;
   localparam int CTRR_REC_WORDS = CTRR_HDR_WORDS + CTRR_STAT_WORDS + CTRR_DATA_WORDS;
   localparam int CTRR_POS_EXT = 0;
   localparam int CTRR_POS_INT = 5;
   localparam int CTRR_POS_BV = 6;
   localparam int CTRR_POS_AV = 9;
   localparam int CTRR_POS_AP = 12;
   localparam int CTRR_POS_TT = 15;
   localparam int CTRR_STD_STAT_W = 16;
   localparam logic [31:0] CTRR_STAT_RESET = 32'h00000000;
   // Latency budget
   localparam int CTRR_CLK_PERIOD_NS = 40;
   localparam int CTRR_MAX_LAT_NS = 500;
   localparam int CTRR_MAX_LAT_CYC = CTRR_MAX_LAT_NS / CTRR_CLK_PERIOD_NS;
   localparam int CTRR_FIFO_DEPTH = 16;
   typedef enum logic [1:0] {CTRR_IDLE, CTRR_SEND} ctrr_state_t;
endpackage

// ### ctrr_stream_if.sv
// Interface carrying record words between framer and output FIFO
interface ctrr_stream_if #(parameter int W = 33);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ### ctrr_fifo.sv
// Synchronous FIFO with registered read data and valid/ready on both sides
module ctrr_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   ctrr_stream_if.snk wr,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wptr_reg, rptr_reg;
   logic full, empty, push, pop;
   assign full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
   assign empty = (wptr_reg == rptr_reg);
   assign wr.ready = !full;
   // Output register counts as a stage: pop when it is free or being drained
   assign pop = !empty && (!rd_valid_out || rd_ready_in);
   assign push = wr.valid && !full;
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_reg[wptr_reg[AW-1:0]] <= wr.data;
      end
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         rd_valid_out <= 1'b0;
         rd_data_out <= '0;
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= rptr_reg + 1'b1;
            rd_data_out <= mem_reg[rptr_reg[AW-1:0]];
            rd_valid_out <= 1'b1;
         end else if (rd_ready_in) begin
            rd_valid_out <= 1'b0;
         end
      end
   end
endmodule

// ### ctrr_sink.sv
// Record sink model standing in for the region builder, with an optional stall pattern
module ctrr_sink (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic stall_in,
   output logic ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_reg;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_reg <= 3'h0;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end
   // Stalling takes one word in eight, so a burst of records backs up into the framer
   assign ready_out = !stall_in || (cnt_reg == 3'h7);
endmodule

// ### central_trigger_readout_record_tb.sv
// Self-checking testbench for the readout record framer
module central_trigger_readout_record_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ctrr_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, acc = 1'b0, stall = 1'b0, rdy;
   logic [CTRR_EXT_IN_W-1:0] ext = '0;
   logic [31:0] intin = '0, ev = '0, seed = 32'h0000EA3E;
   logic [CTRR_ITEMS_W-1:0] bv = '0, av = '0, ap = '0;
   logic [7:0] tt = '0;
   logic [11:0] bc = '0;
   logic [15:0] std = '0, src = '0;
   logic busy, ovr, vld, last;
   logic [31:0] dat;
   logic [31:0] exp_q[$];
   int mismatches = 0, checks = 0, widx = 0, cyc = 0, n;
   ctrr_framer i_ctrr_framer (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .ACCEPT_IN(acc),
      .EXT_INPUTS_IN(ext), .INT_INPUTS_IN(intin), .ITEMS_BEFORE_VETO_IN(bv),
      .ITEMS_AFTER_VETO_IN(av), .ITEMS_AFTER_PRESCALE_IN(ap), .TRIGGER_TYPE_IN(tt),
      .EVENT_NUMBER_IN(ev), .BUNCH_CROSSING_NUMBER_IN(bc), .STATUS_STD_IN(std),
      .STATUS_SRC_IN(src), .BUSY_OUT(busy), .OVERRUN_OUT(ovr), .REC_VALID_OUT(vld),
      .REC_READY_IN(rdy), .REC_DATA_OUT(dat), .REC_LAST_OUT(last));
   ctrr_sink i_ctrr_sink (.clk_in(clk), .arst_n_in(arst_n), .stall_in(stall), .ready_out(rdy));
   initial begin
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      for (int i = 0; i < 32; i++) seed = {seed[30:0], ^(seed & 32'h80200003)};
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic scramble();
      ext = {rnd(), rnd(), rnd(), rnd(), rnd()};
      {intin, ev, src, std, tt, bc} = 116'({rnd(), rnd(), rnd(), rnd()});
      bv = {rnd(), rnd(), rnd()};
      av = {rnd(), rnd(), rnd()};
      ap = {rnd(), rnd(), rnd()};
   endtask
   // Model: header, two status words, then the sixteen data words
   task automatic push_rec();
      exp_q.push_back(ev);
      exp_q.push_back({20'h00000, bc});
      exp_q.push_back({src, std});
      exp_q.push_back(32'h00000000);
      for (int i = 0; i < 5; i++) exp_q.push_back(ext[32*i+:32]);
      exp_q.push_back(intin);
      for (int i = 0; i < 3; i++) exp_q.push_back(bv[32*i+:32]);
      for (int i = 0; i < 3; i++) exp_q.push_back(av[32*i+:32]);
      for (int i = 0; i < 3; i++) exp_q.push_back(ap[32*i+:32]);
      exp_q.push_back({24'h000000, tt});
   endtask
   // One accept; dup holds it a second cycle while busy, which must be refused
   task automatic fire(input bit chk_lat, input bit dup);
      @(posedge clk);
      #1;
      scramble();
      acc = 1'b1;
      push_rec();
      @(posedge clk);
      #1;
      acc = dup;
      scramble();
      check(busy, 1, "busy after accept");
      n = 0;
      if (dup) begin
         @(posedge clk);
         #1;
         acc = 1'b0;
         check(ovr, 1, "overrun");
         n = 1;
      end else begin
         check(ovr, 0, "overrun");
      end
      while (vld !== 1'b1 && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (chk_lat) check(n, 2, "first word latency");
      while (busy !== 1'b0) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (chk_lat) check(n, CTRR_REC_WORDS, "busy length");
   endtask
   task automatic drain(input string name);
      while (exp_q.size() != 0) @(posedge clk);
      repeat (4) @(posedge clk);
      #1;
      $display("test %s done", name);
   endtask
   // Handshake seen at the falling edge is taken at the next rising edge
   always @(negedge clk) begin
      if (vld === 1'b1 && rdy === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(1, 0, "extra word");
         end else begin
            check(dat, exp_q.pop_front(), "record word");
            check(last, widx == CTRR_REC_WORDS - 1, "last flag");
            widx = (widx == CTRR_REC_WORDS - 1) ? 0 : widx + 1;
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      #1;
      arst_n = 1'b1;
      fire(1, 0);
      drain("plain");
      fire(1, 1);
      drain("refused accept");
      stall = 1'b1;
      for (int k = 0; k < 4; k++) fire(0, 0);
      stall = 1'b0;
      drain("back to back with stall");
      summarize();
   end
endmodule
